// File: pin_function_drive_select.v
/*
 pin function routing and source-current selection for port A and port B,
 with an APB register slave; port B carries gpio only and its select
 registers are only stored, for other logic to use;
 assumes pins, peripherals and APB all run on
 clk_sys and that software orders select and enable writes correctly
*/
`timescale 1ns/1ns
`include "pin_function_consts.vh"

// What this block does
// - drive level applies only to push-pull outputs
// - two-bit field gives drive levels zero to three
// - first drive register fields map pin groups
// - second drive register upper bits read zero
// - output and input function select registers exist
// - pin three select codes route listed functions
// - pin two select codes route listed functions
// - pin one select codes route listed functions
// - pin zero select codes route listed functions
// - pin seven select codes route listed functions
// - pin six select codes route listed functions
// - pin five select codes route listed functions
// - pin four select codes route listed functions
// - direction one is input, zero output; reset input
module pin_function_drive_select (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // port a pins
    input wire [7:0] portAIn,
    output reg [7:0] portAOut,
    output reg [7:0] portAOe,
    output reg [15:0] portADrive,
    output reg [7:0] portAAnalog,
    // port b pins
    input wire [7:0] portBIn,
    output reg [7:0] portBOut,
    output reg [7:0] portBOe,
    output reg [15:0] portBDrive,
    // gpio data from port latches
    input wire [7:0] gpioAOut,
    input wire [7:0] gpioBOut,
    // peripheral outputs and enables
    input wire [`PER_COUNT-1:0] perOut,
    input wire [`PER_COUNT-1:0] perOe,
    // shared digital inputs
    output reg [1:0] externalInterruptInput,
    output reg [1:0] timerCaptureInput,
    output reg stdTimerClockInput,
    output reg periodicTimerClockInput,
    // selection for port b and input functions
    output reg [7:0] portOutputFunctionSelectB,
    output reg [7:0] inputFunctionSelect
);

    // software registers; drive level 1 keeps six bits
    reg [7:0] driveLevelSelect0;
    reg [5:0] driveLevelSelect1;
    reg [7:0] portAFunctionSelect0;
    reg [7:0] portAFunctionSelect1;
    reg [7:0] portDirectionA;
    reg [7:0] portDirectionB;

    // read mux and decode hit
    reg [7:0] next_rdata;
    reg addrHit;

    // routing cell select fields, two bits per pin, and results, one bit per pin
    wire [15:0] aSel;
    wire [7:0] cellOut;
    wire [7:0] cellOe;
    wire [7:0] cellGpio;
    wire [7:0] cellAnalog;

    // access phase and drive group levels
    wire accessPhase;
    wire [1:0] lvlPa30;
    wire [1:0] lvlPa74;
    wire [1:0] lvlPb30;
    wire [1:0] lvlPb764;

    // a transfer is taken only in its access phase
    assign accessPhase = psel & penable;

    // select fields packed per pin: pin n at aSel[2n+1:2n]
    assign aSel = {portAFunctionSelect1[7:6],
                   portAFunctionSelect1[5:4],
                   portAFunctionSelect1[3:2],
                   portAFunctionSelect1[1:0],
                   portAFunctionSelect0[7:6],
                   portAFunctionSelect0[5:4],
                   portAFunctionSelect0[3:2],
                   portAFunctionSelect0[1:0]};

    // drive groups from the first level register;
    // port b pin 5 is in none of them
    assign lvlPb764 = driveLevelSelect0[`FLD_HI:`FLD_HI-1];
    assign lvlPb30 = driveLevelSelect0[`FLD_MH:`FLD_MH-1];
    assign lvlPa74 = driveLevelSelect0[`FLD_ML:`FLD_ML-1];
    assign lvlPa30 = driveLevelSelect0[`FLD_LO:`FLD_LO-1];

    // one routing cell per port a pin
    // cells are pure logic, registered below
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1)
        begin : g_pin
            pin_route_cell #(.PIN(i[2:0])) u_cell (
                .sel(aSel[2*i+1:2*i]),
                .dirIn(portDirectionA[i]),
                .gpioOut(gpioAOut[i]),
                .perOut(perOut),
                .perOe(perOe),
                .pinOut(cellOut[i]),
                .pinOe(cellOe[i]),
                .gpioMode(cellGpio[i]),
                .analogMode(cellAnalog[i])
            );
        end
    endgenerate

    // address decode for reads; unmapped reads zero with an error
    // only the low byte lane carries data
    always @*
    begin
        next_rdata = 8'h00;
        addrHit = 1'b1;
        if (paddr == `OFF_DRIVE_LEVEL_SELECT_0)
        begin
            next_rdata = driveLevelSelect0;
        end
        else if (paddr == `OFF_DRIVE_LEVEL_SELECT_1)
        begin
            next_rdata = {2'b00, driveLevelSelect1};
        end
        else if (paddr == `OFF_PORT_A_FUNCTION_SELECT_0)
        begin
            next_rdata = portAFunctionSelect0;
        end
        else if (paddr == `OFF_PORT_A_FUNCTION_SELECT_1)
        begin
            next_rdata = portAFunctionSelect1;
        end
        else if (paddr == `OFF_PORT_DIRECTION_CONTROL_A)
        begin
            next_rdata = portDirectionA;
        end
        else if (paddr == `OFF_PORT_DIRECTION_CONTROL_B)
        begin
            next_rdata = portDirectionB;
        end
        else if (paddr == `OFF_PORT_OUTPUT_FUNCTION_SELECT_B)
        begin
            next_rdata = portOutputFunctionSelectB;
        end
        else if (paddr == `OFF_INPUT_FUNCTION_SELECT)
        begin
            next_rdata = inputFunctionSelect;
        end
        else
        begin
            addrHit = 1'b0;
        end
    end

    // apb: one wait state, pready pulses in the second access cycle
    // ~pready keeps a held request from completing twice
    // prdata holds until the next read
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            pready <= accessPhase & ~pready;
            pslverr <= accessPhase & ~pready & ~addrHit;
            if (accessPhase & ~pready & ~pwrite)
            begin
                prdata <= {24'h00_0000, next_rdata};
            end
        end
    end

    // register writes take effect at the edge that completes the transfer
    // unmapped writes change nothing
    // bits above a register's width are dropped
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            driveLevelSelect0 <= `RST_DRIVE_LEVEL;
            driveLevelSelect1 <= 6'h00;
            portAFunctionSelect0 <= `RST_FUNCTION_SELECT;
            portAFunctionSelect1 <= `RST_FUNCTION_SELECT;
            portDirectionA <= `RST_DIRECTION;
            portDirectionB <= `RST_DIRECTION;
            portOutputFunctionSelectB <= `RST_FUNCTION_SELECT;
            inputFunctionSelect <= `RST_FUNCTION_SELECT;
        end
        else if (accessPhase & pready & pwrite)
        begin
            if (paddr == `OFF_DRIVE_LEVEL_SELECT_0)
            begin
                driveLevelSelect0 <= pwdata[7:0];
            end
            else if (paddr == `OFF_DRIVE_LEVEL_SELECT_1)
            begin
                driveLevelSelect1 <= pwdata[5:0];
            end
            else if (paddr == `OFF_PORT_A_FUNCTION_SELECT_0)
            begin
                portAFunctionSelect0 <= pwdata[7:0];
            end
            else if (paddr == `OFF_PORT_A_FUNCTION_SELECT_1)
            begin
                portAFunctionSelect1 <= pwdata[7:0];
            end
            else if (paddr == `OFF_PORT_DIRECTION_CONTROL_A)
            begin
                portDirectionA <= pwdata[7:0];
            end
            else if (paddr == `OFF_PORT_DIRECTION_CONTROL_B)
            begin
                portDirectionB <= pwdata[7:0];
            end
            else if (paddr == `OFF_PORT_OUTPUT_FUNCTION_SELECT_B)
            begin
                portOutputFunctionSelectB <= pwdata[7:0];
            end
            else if (paddr == `OFF_INPUT_FUNCTION_SELECT)
            begin
                inputFunctionSelect <= pwdata[7:0];
            end
        end
    end

    // registered pin outputs; drive level forced to 0 unless push-pull
    // output, so pad strength never changes on an input or analog pin
    integer n;
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            portAOut <= 8'h00;
            portAOe <= 8'h00;
            portADrive <= 16'h0000;
            portAAnalog <= 8'h00;

            portBOut <= 8'h00;
            portBOe <= 8'h00;
            portBDrive <= 16'h0000;
        end
        else
        begin
            portAOut <= cellOut;
            portAOe <= cellOe;
            portAAnalog <= cellAnalog;

            // port b has no routing, gpio only
            portBOut <= gpioBOut;
            portBOe <= ~portDirectionB;
            for (n = 0; n < 8; n = n + 1)
            begin
                // level passes only while the pin drives push-pull
                if (!cellOe[n])
                begin
                    portADrive[2*n +: 2] <= 2'b00;
                end
                else if (n < 4)
                begin
                    // port a groups split at pin 4
                    portADrive[2*n +: 2] <= lvlPa30;
                end
                else
                begin
                    portADrive[2*n +: 2] <= lvlPa74;
                end
                if (portDirectionB[n])
                begin
                    portBDrive[2*n +: 2] <= 2'b00;
                end
                else if (n < 4)
                begin
                    portBDrive[2*n +: 2] <= lvlPb30;
                end
                else if (n == 5)
                begin
                    // pin 5 takes the second register's low field
                    portBDrive[2*n +: 2] <= driveLevelSelect1[1:0];
                end
                else
                begin
                    portBDrive[2*n +: 2] <= lvlPb764;
                end
            end
        end
    end

    // shared digital inputs see the pin whenever gpio code is selected;
    // consumers gate them with their own enables
    always @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            externalInterruptInput <= 2'b00;
            timerCaptureInput <= 2'b00;
            stdTimerClockInput <= 1'b0;
            periodicTimerClockInput <= 1'b0;
        end
        else
        begin
            // interrupt inputs
            externalInterruptInput[0] <= cellGpio[3] & portAIn[3];
            externalInterruptInput[1] <= cellGpio[1] & portAIn[1];

            // pa3 feeds interrupt 0 and capture 1 at once
            timerCaptureInput[1] <= cellGpio[3] & portAIn[3];
            timerCaptureInput[0] <= cellGpio[7] & portAIn[7];
            stdTimerClockInput <= cellGpio[5] & portAIn[5];
            periodicTimerClockInput <= cellGpio[4] & portAIn[4];
        end
    end

endmodule // pin_function_drive_select

// File: pin_function_consts.vh
/*
 holds register offsets, field positions, reset values and select codes
 for the pin function and drive level block; assumes a 32-bit APB slave
*/
`ifndef PIN_FUNCTION_CONSTS_VH
`define PIN_FUNCTION_CONSTS_VH

// register byte offsets
`define OFF_DRIVE_LEVEL_SELECT_0 12'h000
`define OFF_DRIVE_LEVEL_SELECT_1 12'h004
`define OFF_PORT_A_FUNCTION_SELECT_0 12'h008
`define OFF_PORT_A_FUNCTION_SELECT_1 12'h00C
`define OFF_PORT_DIRECTION_CONTROL_A 12'h010
`define OFF_PORT_DIRECTION_CONTROL_B 12'h014
`define OFF_PORT_OUTPUT_FUNCTION_SELECT_B 12'h018
`define OFF_INPUT_FUNCTION_SELECT 12'h01C

// reset values
`define RST_DRIVE_LEVEL 8'h00
`define RST_FUNCTION_SELECT 8'h00
`define RST_DIRECTION 8'hFF
`define DRIVE1_MASK 8'h3F

// pin select codes
`define SEL_00 2'b00
`define SEL_01 2'b01
`define SEL_10 2'b10
`define SEL_11 2'b11

// field positions
`define FLD_HI 7
`define FLD_MH 5
`define FLD_ML 3
`define FLD_LO 1

// peripheral output vector indices
`define PER_SDO 0
`define PER_SCS 1
`define PER_SCK 2
`define PER_SDA 3
`define PER_UART 4
`define PER_T2B 5
`define PER_T1B 6
`define PER_T0 7
`define PER_ST1B 8
`define PER_ST0B 9
`define PER_COUNT 10

`endif

// File: pin_route_cell.v
/*
 one port A pin: picks the drive source and enable from its 2-bit select
 code and the direction bit; assumes peripheral outputs are synchronous
*/
`timescale 1ns/1ns
`include "pin_function_consts.vh"

module pin_route_cell #(
    parameter [2:0] PIN = 3'd0
)
(
    // select and direction
    input wire [1:0] sel,
    input wire dirIn,
    input wire gpioOut,
    // peripheral outputs
    input wire [`PER_COUNT-1:0] perOut,
    input wire [`PER_COUNT-1:0] perOe,
    // pin side
    output reg pinOut,
    output reg pinOe,
    output reg gpioMode,
    output reg analogMode
);

    // combinational route per pin number
    always @*
    begin
        pinOut = gpioOut;
        pinOe = ~dirIn;
        gpioMode = 1'b0;
        analogMode = 1'b0;
        case (PIN)
            3'd3:
            begin
                if (sel == `SEL_00) gpioMode = 1'b1;
                else if (sel == `SEL_01)
                begin
                    pinOut = perOut[`PER_SDO];
                    pinOe = 1'b1;
                end
                else if (sel == `SEL_11)
                begin
                    analogMode = 1'b1;
                    pinOe = 1'b0;
                end
                else pinOe = 1'b0; // unlisted code parks the pin
            end
            3'd2:
            begin
                if (sel == `SEL_00) gpioMode = 1'b1;
                else if (sel == `SEL_01)
                begin
                    pinOut = perOut[`PER_SDA];
                    pinOe = perOe[`PER_SDA];
                end
                else if (sel == `SEL_10)
                begin
                    pinOut = perOut[`PER_UART];
                    pinOe = perOe[`PER_UART];
                end
                else
                begin
                    pinOut = perOut[`PER_T2B];
                    pinOe = 1'b1;
                end
            end
            3'd1:
            begin
                if (sel == `SEL_00) gpioMode = 1'b1;
                else if (sel == `SEL_01)
                begin
                    pinOut = perOut[`PER_SCS];
                    pinOe = perOe[`PER_SCS];
                end
                else
                begin
                    analogMode = 1'b1; // op-amp output or positive input
                    pinOe = 1'b0;
                end
            end
            3'd0:
            begin
                if (sel == `SEL_00 || sel == `SEL_11) gpioMode = 1'b1;
                else if (sel == `SEL_01)
                begin
                    pinOut = perOut[`PER_SCK];
                    pinOe = perOe[`PER_SCK];
                end
                else
                begin
                    pinOut = perOut[`PER_T1B];
                    pinOe = 1'b1;
                end
            end
            3'd7:
            begin
                if (sel == `SEL_00) gpioMode = 1'b1;
                else if (sel == `SEL_01)
                begin
                    pinOut = perOut[`PER_SCK];
                    pinOe = perOe[`PER_SCK];
                end
                else
                begin
                    analogMode = 1'b1; // analog input or reference
                    pinOe = 1'b0;
                end
            end
            3'd6:
            begin
                if (sel == `SEL_00) gpioMode = 1'b1;
                else if (sel == `SEL_01)
                begin
                    pinOut = perOut[`PER_T0];
                    pinOe = 1'b1;
                end
                else if (sel == `SEL_10)
                begin
                    pinOut = perOut[`PER_SDA];
                    pinOe = perOe[`PER_SDA];
                end
                else
                begin
                    pinOut = perOut[`PER_UART];
                    pinOe = perOe[`PER_UART];
                end
            end
            3'd5:
            begin
                if (sel == `SEL_00 || sel == `SEL_11) gpioMode = 1'b1;
                else if (sel == `SEL_01)
                begin
                    pinOut = perOut[`PER_ST1B];
                    pinOe = 1'b1;
                end
                else
                begin
                    analogMode = 1'b1;
                    pinOe = 1'b0;
                end
            end
            default:
            begin
                if (sel == `SEL_00) gpioMode = 1'b1;
                else if (sel == `SEL_01)
                begin
                    pinOut = perOut[`PER_ST0B];
                    pinOe = 1'b1;
                end
                else
                begin
                    analogMode = 1'b1; // analog input 0 or op-amp 0 output
                    pinOe = 1'b0;
                end
            end
        endcase
        if (gpioMode)
            pinOe = ~dirIn;
    end

endmodule // pin_route_cell

// File: pin_function_drive_select_props.sv
/*
 port checker for the pin function and drive level block
 assumes apb, pins and peripherals all run on clk_sys
*/
`timescale 1ns/1ns
`include "pin_function_consts.vh"

module pin_function_drive_select_props (
    // clock and reset
    input wire clk_sys,
    input wire rst_n,
    // apb
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // pins
    input wire [7:0] portAIn,
    input wire [7:0] portAOe,
    input wire [15:0] portADrive,
    input wire [7:0] portBOe,
    input wire [15:0] portBDrive,
    input wire [1:0] externalInterruptInput,
    input wire [7:0] portOutputFunctionSelectB
);
    wire [15:0] aOe2;
    wire [15:0] bOe2;
    wire selBWr;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // each enable covers its pin's two drive bits
    genvar g;
    for (g = 0; g < 8; g = g + 1)
    begin : g_spread
        assign aOe2[2*g+1:2*g] = {2{portAOe[g]}};
        assign bOe2[2*g+1:2*g] = {2{portBOe[g]}};
    end
    // a write lands at the pready edge and shows one edge later
    assign selBWr = pready && pwrite && paddr == `OFF_PORT_OUTPUT_FUNCTION_SELECT_B;

    AST_READY_PULSE:
        assert property (pready |=> !pready) else $error("ready held too long");
    AST_READY_IN_ACCESS:
        assert property (pready |-> psel && penable) else $error("ready outside access");
    AST_ERR_WITH_READY:
        assert property (pslverr |-> pready) else $error("error without ready");
    AST_READY_BOUND:
        assert property (psel && penable && !pready |-> ##[1:2] pready)
        else $error("ready late");
    AST_UNMAPPED_ERR:
        assert property (pready && paddr > 12'h01C |-> pslverr) else $error("no error");
    AST_MAPPED_OK:
        assert property (pready && paddr <= 12'h01C |-> !pslverr) else $error("false error");
    AST_DRIVE1_TOP_ZERO:
        assert property (pready && !pwrite && paddr == `OFF_DRIVE_LEVEL_SELECT_1
            |-> prdata[7:6] == 2'b00) else $error("unimplemented bits read set");
    AST_A_DRIVE_GATED:
        assert property ((portADrive & ~aOe2) == 16'h0000) else $error("port a drive leak");
    AST_B_DRIVE_GATED:
        assert property ((portBDrive & ~bOe2) == 16'h0000) else $error("port b drive leak");
    AST_RESET_INPUT:
        assert property ($rose(rst_n) |-> (portAOe == 8'h00 && portBOe == 8'h00)[*3])
        else $error("pin driven after reset");
    AST_SELB_CAUSE:
        assert property ($changed(portOutputFunctionSelectB)
            |-> $past(selBWr) || $past(selBWr, 2) || $past(selBWr, 3))
        else $error("select changed without write");
    AST_INT_FOLLOWS_PIN:
        assert property (externalInterruptInput[0] |-> $past(portAIn[3]) || $past(portAIn[3], 2))
        else $error("interrupt input without pin high");

    cover property (pslverr);
    cover property (portADrive != 16'h0000);
    cover property (externalInterruptInput[0]);
endmodule // pin_function_drive_select_props

// File: pin_function_drive_select_tb_top.sv
/*
 self-checking bench for the pin function and drive level block
 assumes the design answers apb with its own pready
*/
`timescale 1ns/1ns
`include "pin_function_consts.vh"

module pin_function_drive_select_tb_top;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [7:0] portAIn = 8'h00;
    logic [7:0] portBIn = 8'h00;
    logic [7:0] gpioAOut = 8'h00;
    logic [7:0] gpioBOut = 8'h3C;
    logic [`PER_COUNT-1:0] perOut = 10'h000;
    logic [`PER_COUNT-1:0] perOe = 10'h000;
    wire [31:0] prdata;
    wire pready, pslverr, stdTimerClockInput, periodicTimerClockInput;
    wire [7:0] portAOut, portAOe, portAAnalog, portBOut, portBOe;
    wire [7:0] portOutputFunctionSelectB, inputFunctionSelect;
    wire [15:0] portADrive, portBDrive;
    wire [1:0] externalInterruptInput, timerCaptureInput;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cyc = 0;
    // pin source per code: 0..9 peripheral, 13 released, 14 analog, 15 gpio
    int srcTab [8][4] = '{'{15,2,6,15}, '{15,1,14,14}, '{15,3,4,5}, '{15,0,13,14},
        '{15,9,14,14}, '{15,8,14,15}, '{15,7,3,4}, '{15,2,14,14}};
    logic [7:0] rstV [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};
    logic [7:0] mskV [8] = '{8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
    logic [9:0] outOnly = 10'h3E1; // drive whenever selected

    pin_function_drive_select i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .portAIn(portAIn), .portAOut(portAOut),
        .portAOe(portAOe), .portADrive(portADrive), .portAAnalog(portAAnalog),
        .portBIn(portBIn), .portBOut(portBOut), .portBOe(portBOe), .portBDrive(portBDrive),
        .gpioAOut(gpioAOut), .gpioBOut(gpioBOut), .perOut(perOut), .perOe(perOe),
        .externalInterruptInput(externalInterruptInput), .timerCaptureInput(timerCaptureInput),
        .stdTimerClockInput(stdTimerClockInput), .periodicTimerClockInput(periodicTimerClockInput),
        .portOutputFunctionSelectB(portOutputFunctionSelectB),
        .inputFunctionSelect(inputFunctionSelect));

    always #5 clk_sys = ~clk_sys;

    // hang guard, far above the few hundred cycles the run needs
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end

    task give_verdict;
        if (n_mismatch == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            n_mismatch++;
        end
    endtask

    // one apb transfer; one idle edge after so psel never toggles twice at once
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rdata, output logic err);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_sys);
        penable <= 1'b1;
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task wr(input logic [11:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h00_0000, d}, r, e);
    endtask

    task rdChk(input string nm, input logic [11:0] a, input logic [7:0] exp, input logic ee);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0000_0000, r, e);
        chk(nm, {24'h00_0000, exp}, r);
        chk(nm, {31'h0000_0000, ee}, {31'h0000_0000, e});
    endtask

    // registered pin outputs lag the write by one edge; settle waits three
    task settle;
        repeat (3) @(posedge clk_sys);
    endtask

    function automatic logic [15:0] spread(input logic [7:0] dir, input logic [15:0] lv);
        for (int n = 0; n < 8; n++)
            spread[2*n+:2] = dir[n] ? 2'b00 : lv[2*n+:2];
    endfunction

    initial
    begin
        logic [7:0] d0, d1, eO, eE, eN, m;
        logic [1:0] ex;
        int s;
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        chk("oe after reset", 32'h0000_0000, {portAOe, portBOe});
        // reset values, then read back through the writable masks
        for (int i = 0; i < 8; i++)
            rdChk("reset value", 12'(i * 4), rstV[i], 1'b0);
        for (int i = 0; i < 8; i++)
            wr(12'(i * 4), 8'hE7);
        for (int i = 0; i < 8; i++)
            rdChk("read back", 12'(i * 4), 8'hE7 & mskV[i], 1'b0);
        chk("out select b", 32'h0000_00E7, portOutputFunctionSelectB);
        chk("input select", 32'h0000_00E7, inputFunctionSelect);
        wr(12'h020, 8'h55);
        rdChk("unmapped", 12'h020, 8'h00, 1'b1);
        // drive levels in gpio mode with mixed directions
        wr(`OFF_PORT_A_FUNCTION_SELECT_0, 8'h00);
        wr(`OFF_PORT_A_FUNCTION_SELECT_1, 8'h00);
        wr(`OFF_PORT_DIRECTION_CONTROL_A, 8'h5A);
        wr(`OFF_PORT_DIRECTION_CONTROL_B, 8'hC3);
        for (int k = 0; k < 4; k++)
        begin
            d0 = {2'(k), 2'(k + 1), 2'(k + 2), 2'(k + 3)};
            d1 = {6'h3F, 2'(k + 2)};
            wr(`OFF_DRIVE_LEVEL_SELECT_0, d0);
            wr(`OFF_DRIVE_LEVEL_SELECT_1, d1);
            settle();
            chk("a drive", spread(8'h5A, {{4{d0[3:2]}}, {4{d0[1:0]}}}), portADrive);
            chk("b drive", spread(8'hC3, {{2{d0[7:6]}}, d1[1:0], d0[7:6], {4{d0[5:4]}}}),
                portBDrive);
            chk("dir oe", 32'h0000_A53C, {portAOe, portBOe});
            chk("b out", 32'h0000_003C, portBOut);
        end
        // every select code on every port a pin, two data patterns each
        wr(`OFF_PORT_DIRECTION_CONTROL_A, 8'hBA);
        for (int c = 0; c < 4; c++)
        begin
            perOe <= 10'h000;
            wr(`OFF_PORT_A_FUNCTION_SELECT_0, {4{2'(c)}});
            wr(`OFF_PORT_A_FUNCTION_SELECT_1, {4{2'(c)}});
            for (int p = 0; p < 2; p++)
            begin
                perOut <= p ? 10'h2B4 : 10'h14B;
                perOe <= p ? 10'h1E6 : 10'h219;
                gpioAOut <= p ? 8'h96 : 8'h69;
                portAIn <= p ? 8'hFF : 8'h00;
                settle();
                eO = 8'h00;
                eE = 8'h00;
                eN = 8'h00;
                m = 8'h00;
                for (int n = 0; n < 8; n++)
                begin
                    s = srcTab[n][c];
                    eN[n] = (s == 14);
                    m[n] = (s == 15 || s < 10);
                    eO[n] = (s == 15) ? gpioAOut[n] : (s < 10) ? perOut[s] : 1'b0;
                    eE[n] = (s == 15) ? !s_dir(n) : (s < 10) ? perOe[s] | outOnly[s] : 1'b0;
                end
                chk("a out", eO, portAOut & m);
                chk("a oe", eE, portAOe);
                chk("a analog", eN, portAAnalog);
                ex = (c == 0) ? {2{p[0]}} : 2'b00;
                chk("shared inputs", {ex, ex, (c == 0 || c == 3) && p[0], c == 0 && p[0]},
                    {externalInterruptInput, timerCaptureInput, stdTimerClockInput,
                    periodicTimerClockInput});
            end
        end
        give_verdict();
    end

    // port a direction used by the routing pass
    function automatic logic s_dir(input int n);
        logic [7:0] d;
        d = 8'hBA;
        return d[n];
    endfunction
endmodule // pin_function_drive_select_tb_top

bind pin_function_drive_select pin_function_drive_select_props i_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .portAIn(portAIn),
    .portAOe(portAOe), .portADrive(portADrive), .portBOe(portBOe), .portBDrive(portBDrive),
    .externalInterruptInput(externalInterruptInput),
    .portOutputFunctionSelectB(portOutputFunctionSelectB));
